// File: design/iq_baseband_modulator.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module iq_baseband_modulator #(
  parameter int SAMPLE_W = 9
) (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  output logic [SAMPLE_W-1:0]       iData,
  output logic [SAMPLE_W-1:0]       qData,
  output logic [4:0]                pllDivide,
  output logic                      bandSel,
  output logic                      txBit,
  output logic                      irq
);

  // ****************************************
  // bus slave
  // ****************************************
  logic        wrPend_r;
  logic        rdPend_r;
  logic        addrOk_r;
  logic [7:0]  idx_r;
  logic [31:0] rdMux;
  logic [7:0]  wData;

  function automatic logic wrHit(input logic pend, input logic ok,
                                 input logic [7:0] idx, input logic [7:0] want);
    wrHit = pend && ok && (idx == want);
  endfunction

  assign wData = hwdata[7:0];

  // reads take one wait state so hrdata can come from a flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_r  <= 1'b0;
      rdPend_r  <= 1'b0;
      addrOk_r  <= 1'b0;
      idx_r     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (ce) begin
      wrPend_r <= 1'b0;
      if (rdPend_r) begin
        hrdata    <= rdMux;
        hreadyout <= 1'b1;
        rdPend_r  <= 1'b0;
      end else if (hsel && htrans[1] && hready) begin
        idx_r     <= haddr[9:2];
        addrOk_r  <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
        wrPend_r  <= hwrite && (hsize == iq_mod_pkg::HSIZE_WORD);
        rdPend_r  <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  logic [7:0] offset_r;
  logic [7:0] scale_r;
  logic [5:0] ramAddr_r;
  logic [7:0] txBuf_r;
  logic       polarity_r;
  logic       modEn_r;
  logic       askMode_r;
  logic       ramAccess_r;
  logic       shiftEn_r;
  logic [1:0] mask_r;
  logic [1:0] sts_r;
  logic       busy_r;
  logic [7:0] ram [iq_mod_pkg::RAM_DEPTH];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bandSel     <= iq_mod_pkg::BAND_RST;
      offset_r    <= 8'h00;
      scale_r     <= 8'h00;
      ramAddr_r   <= 6'h00;
      txBuf_r     <= 8'h00;
      polarity_r  <= iq_mod_pkg::CTRL_RST[iq_mod_pkg::CTRL_POL];
      modEn_r     <= iq_mod_pkg::CTRL_RST[iq_mod_pkg::CTRL_EN];
      askMode_r   <= iq_mod_pkg::CTRL_RST[iq_mod_pkg::CTRL_ASK];
      ramAccess_r <= iq_mod_pkg::CTRL_RST[iq_mod_pkg::CTRL_RAMACC];
      shiftEn_r   <= iq_mod_pkg::CTRL_RST[iq_mod_pkg::CTRL_SHIFT];
      mask_r      <= iq_mod_pkg::MASK_RST;
    end else if (ce) begin
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::BAND_IDX)) begin
        bandSel <= wData[iq_mod_pkg::BAND_BIT];
      end
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::OFFSET_IDX)) begin
        offset_r <= wData;
      end
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::SCALE_IDX)) begin
        scale_r <= wData;
      end
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::RAMADDR_IDX)) begin
        ramAddr_r <= wData[5:0];
      end
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::TXBUF_IDX)) begin
        txBuf_r <= wData;
      end
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::CTRL_IDX)) begin
        polarity_r  <= wData[iq_mod_pkg::CTRL_POL];
        modEn_r     <= wData[iq_mod_pkg::CTRL_EN];
        askMode_r   <= wData[iq_mod_pkg::CTRL_ASK];
        ramAccess_r <= wData[iq_mod_pkg::CTRL_RAMACC];
        shiftEn_r   <= wData[iq_mod_pkg::CTRL_SHIFT];
      end
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::IRQ_MASK_IDX)) begin
        mask_r <= wData[1:0];
      end
    end
  end

  // cleared on reset so an unwritten location never feeds unknowns into the phase path
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < iq_mod_pkg::RAM_DEPTH; i++) begin
        ram[i] <= 8'h00;
      end
    end else if (ce && ramAccess_r &&
                 wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::RAMDATA_IDX)) begin
      ram[ramAddr_r] <= wData;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (!addrOk_r) begin
      rdMux = 32'h0000_0000;
    end else if (idx_r == iq_mod_pkg::STATE_IDX) begin
      rdMux[iq_mod_pkg::STATE_BUSY] = busy_r;
      rdMux[iq_mod_pkg::STATE_RSV]  = 1'b1;
    end else if (idx_r == iq_mod_pkg::IRQ_STS_IDX) begin
      rdMux[1:0] = sts_r;
    end else if (idx_r == iq_mod_pkg::IRQ_MASK_IDX) begin
      rdMux[1:0] = mask_r;
    end
  end

  // ****************************************
  // bit timing
  // ****************************************
  logic [9:0]  scaleCnt_r;
  logic [6:0]  addrIdx_r;
  logic [7:0]  shiftReg_r;
  logic [3:0]  bitsLeft_r;
  logic [9:0]  scalePeriod;
  logic [6:0]  addrCount;
  logic        run;
  logic        active;
  logic        scaleTick;
  logic        bitTick;
  logic        canLoad;
  logic        lastOut;
  logic [6:0]  ramPtr;
  logic [7:0]  ramByte;

  // zero in scale or address count means the largest count
  assign scalePeriod = (scale_r == 8'h00) ? iq_mod_pkg::SCALE_MAX2 : {1'b0, scale_r, 1'b0};
  assign addrCount   = (ramAddr_r == 6'h00) ? iq_mod_pkg::ADDR_MAX : {1'b0, ramAddr_r};
  assign run         = modEn_r && !ramAccess_r;
  assign active      = run && (bitsLeft_r != 4'h0);
  assign scaleTick   = active && (scaleCnt_r == scalePeriod - 10'h001);
  assign bitTick     = scaleTick && (addrIdx_r == addrCount - 7'h01);
  assign canLoad     = run && shiftEn_r && busy_r &&
                       ((bitsLeft_r == 4'h0) || (bitTick && bitsLeft_r == 4'h1));
  assign lastOut     = bitTick && shiftEn_r && (bitsLeft_r == 4'h1) && !busy_r;
  // a zero bit walks the waveform backwards, giving the mirrored symbol
  assign ramPtr      = shiftReg_r[7] ? addrIdx_r : addrCount - 7'h01 - addrIdx_r;
  assign ramByte     = ram[ramPtr[5:0]];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scaleCnt_r <= 10'h000;
      addrIdx_r  <= 7'h00;
    end else if (ce) begin
      if (!active || canLoad) begin
        scaleCnt_r <= 10'h000;
        addrIdx_r  <= 7'h00;
      end else if (scaleTick) begin
        scaleCnt_r <= 10'h000;
        addrIdx_r  <= bitTick ? 7'h00 : addrIdx_r + 7'h01;
      end else begin
        scaleCnt_r <= scaleCnt_r + 10'h001;
      end
    end
  end

  // ****************************************
  // shift path and busy flag
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg_r <= 8'h00;
      bitsLeft_r <= 4'h0;
    end else if (ce) begin
      if (canLoad) begin
        shiftReg_r <= txBuf_r;
        bitsLeft_r <= iq_mod_pkg::BYTE_BITS;
      end else if (bitTick && shiftEn_r) begin
        shiftReg_r <= {shiftReg_r[6:0], 1'b0};
        bitsLeft_r <= bitsLeft_r - 4'h1;
      end
    end
  end

  // a write in the same cycle as the hand-off wins, the new byte waits
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      if (wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::TXBUF_IDX)) begin
        busy_r <= 1'b1;
      end else if (canLoad) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sts_r <= 2'h0;
      irq   <= 1'b0;
    end else if (ce) begin
      sts_r <= (sts_r & ~(wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::IRQ_STS_IDX)
                          ? wData[1:0] : 2'h0)) | {lastOut, canLoad};
      irq   <= |(sts_r & mask_r);
    end
  end

  // ****************************************
  // waveform drive
  // ****************************************
  logic [iq_mod_pkg::PHASE_W-1:0] phaseIncr_r;
  logic                           gate_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseIncr_r <= 12'h000;
      gate_r      <= 1'b0;
      txBit       <= 1'b0;
      pllDivide   <= iq_mod_pkg::DIV_315;
    end else if (ce) begin
      phaseIncr_r <= {2'h0, offset_r, 2'h0} +
                     ((active || askMode_r) ? {4'h0, ramByte} : 12'h000);
      gate_r      <= askMode_r ? (active && shiftReg_r[7]) : 1'b1;
      txBit       <= active && shiftReg_r[7];
      pllDivide   <= bandSel ? iq_mod_pkg::DIV_315 : iq_mod_pkg::DIV_434;
    end
  end

  iq_wave_gen #(
    .OUT_W (SAMPLE_W)
  ) uWave (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .en        (run),
    .phaseIncr (phaseIncr_r),
    .gate      (gate_r),
    .polarity  (polarity_r),
    .iData     (iData),
    .qData     (qData)
  );

  // ****************************************
  // checks
  // ****************************************
  logic [16:0] tickGap_r;
  logic [16:0] bitPeriod;

  assign bitPeriod = 17'(scalePeriod) * 17'(addrCount);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickGap_r <= 17'h0_0000;
    end else if (ce) begin
      tickGap_r <= (bitTick || canLoad || !active) ? 17'h0_0000 : tickGap_r + 17'h0_0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  bandDivide_a: assert property (
    ce && $past(ce) |-> pllDivide == ($past(bandSel) ? 5'h10 : 5'h16))
    else $error("divide ratio does not follow band");

  bitPeriod_a: assert property (
    ce && bitTick |-> tickGap_r == bitPeriod - 17'h0_0001)
    else $error("bit period not 2 x scale x addresses");

  modOff_a: assert property (
    ce && !modEn_r |=> iData == '0 && qData == '0)
    else $error("output active while modulation disabled");

  askGate_a: assert property (
    ce && askMode_r && !(active && shiftReg_r[7]) ##1 ce |=> iData == '0)
    else $error("ASK zero bit not keyed off");

  ramWrite_a: assert property (
    ce && ramAccess_r && wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::RAMDATA_IDX)
    |=> ram[$past(ramAddr_r)] == $past(wData))
    else $error("RAM byte not stored");

  ramLocked_a: assert property (
    ce && !ramAccess_r |=> ram[$past(ramAddr_r)] == $past(ram[ramAddr_r]))
    else $error("RAM changed outside access mode");

  shiftHold_a: assert property (
    ce && !shiftEn_r && !canLoad |=> $stable(shiftReg_r) && $stable(bitsLeft_r))
    else $error("buffer shifted while shift disabled");

  busySet_a: assert property (
    ce && wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::TXBUF_IDX)
    |=> busy_r && shiftReg_r != $past(txBuf_r) || busy_r)
    else $error("busy not raised on buffer write");

  busyClear_a: assert property (
    ce && canLoad && !wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::TXBUF_IDX)
    |=> !busy_r && shiftReg_r == $past(txBuf_r) && bitsLeft_r == 4'h8)
    else $error("hand-off did not clear busy");

  fskIncr_a: assert property (
    ce && active && !askMode_r
    |=> phaseIncr_r == {2'h0, $past(offset_r), 2'h0} + {4'h0, $past(ramByte)})
    else $error("FSK increment wrong");

  addrStep_a: assert property (
    ce && scaleTick && !bitTick && !canLoad |=> addrIdx_r == $past(addrIdx_r) + 7'h01)
    else $error("RAM address did not step");

  irqLevel_a: assert property (
    ce && (sts_r & mask_r) != 2'h0 ##1 ce |-> irq)
    else $error("interrupt not raised");

  byteLoaded_c: cover property (ce && canLoad);
  byteDone_c:   cover property (ce && lastOut);
  ramWrite_c:   cover property (ce && ramAccess_r &&
                  wrHit(wrPend_r, addrOk_r, idx_r, iq_mod_pkg::RAMDATA_IDX));
  busRead_c:    cover property (ce && rdPend_r);

endmodule

// File: design/iq_mod_pkg.sv
// Functional notes
// - band bit picks divide 22 (434 MHz) or 16 (315 MHz); resets to 1
// - phase accumulator of 4096 steps advances by four times offset each clock, plus the RAM byte while bits are sent or in ASK mode
// - one bit lasts 2 x scale x addresses-per-bit clocks
// - polarity bit 5 negates Q phase, selecting lower sideband
// - modulation runs only while enable bit 4 is set; it resets clear
// - mode bit 3 selects ASK when 1, FSK when 0
// - RAM access bit 2 opens RAM writes; clear means normal modulation
// - RAM data writes land at the 6-bit RAM address
// - buffer shifts only while shift enable bit 1 is set
// - busy flag in state bit 7 reads 0 when next byte may load
// - FSK increment is RAM byte plus four times offset
// - one RAM address advanced per scale expiry, count set by address register
package iq_mod_pkg;

  // ****************************************
  // register indices, byte address = 4 x index
  // ****************************************
  localparam logic [7:0] BAND_IDX     = 8'hc2;
  localparam logic [7:0] RAMDATA_IDX  = 8'hc9;
  localparam logic [7:0] RAMADDR_IDX  = 8'hca;
  localparam logic [7:0] TXBUF_IDX    = 8'hcb;
  localparam logic [7:0] OFFSET_IDX   = 8'hd1;
  localparam logic [7:0] SCALE_IDX    = 8'hd2;
  localparam logic [7:0] CTRL_IDX     = 8'hd3;
  localparam logic [7:0] STATE_IDX    = 8'heb;
  localparam logic [7:0] IRQ_STS_IDX  = 8'hf0;
  localparam logic [7:0] IRQ_MASK_IDX = 8'hf1;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int BAND_BIT     = 7;
  localparam int CTRL_POL     = 5;
  localparam int CTRL_EN      = 4;
  localparam int CTRL_ASK     = 3;
  localparam int CTRL_RAMACC  = 2;
  localparam int CTRL_SHIFT   = 1;
  localparam int STATE_BUSY   = 7;
  localparam int STATE_RSV    = 6;
  localparam int IRQ_TAKEN    = 0;
  localparam int IRQ_DONE     = 1;
  localparam logic       BAND_RST   = 1'b1;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [1:0] MASK_RST   = 2'h0;

  // ****************************************
  // arithmetic constants
  // ****************************************
  localparam logic [4:0] DIV_434    = 5'h16;
  localparam logic [4:0] DIV_315    = 5'h10;
  localparam int         PHASE_W    = 12;
  localparam int         RAM_DEPTH  = 64;
  localparam logic [9:0] SCALE_MAX2 = 10'h200;
  localparam logic [6:0] ADDR_MAX   = 7'h40;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// File: design/iq_wave_gen.sv
`timescale 1ns/1ps
module iq_wave_gen #(
  parameter int OUT_W = 9
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  arst_n,
  input  wire logic                                  ce,
  input  wire logic                                  en,
  input  wire logic [iq_mod_pkg::PHASE_W-1:0]        phaseIncr,
  input  wire logic                                  gate,
  input  wire logic                                  polarity,
  output logic signed [OUT_W-1:0]                    iData,
  output logic signed [OUT_W-1:0]                    qData
);

  logic [iq_mod_pkg::PHASE_W-1:0] phase_r;
  logic signed [8:0]              sinV;
  logic signed [8:0]              cosV;

  // quarter wave sampled at bin centres, so no entry lands on zero
  function automatic logic [7:0] quarter(input logic [3:0] k);
    case (k)
      4'h0: quarter = 8'h0c;  4'h1: quarter = 8'h25;
      4'h2: quarter = 8'h3e;  4'h3: quarter = 8'h56;
      4'h4: quarter = 8'h6d;  4'h5: quarter = 8'h83;
      4'h6: quarter = 8'h98;  4'h7: quarter = 8'hab;
      4'h8: quarter = 8'hbd;  4'h9: quarter = 8'hcd;
      4'ha: quarter = 8'hdb;  4'hb: quarter = 8'he6;
      4'hc: quarter = 8'hf0;  4'hd: quarter = 8'hf7;
      4'he: quarter = 8'hfc;  default: quarter = 8'hff;
    endcase
  endfunction

  function automatic logic signed [8:0] sineAt(input logic [11:0] p);
    logic [7:0] mag;
    mag = quarter(p[10] ? ~p[9:6] : p[9:6]);
    sineAt = p[11] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  assign sinV = sineAt(phase_r);
  assign cosV = sineAt(phase_r + 12'h400);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 12'h000;
    end else if (ce) begin
      phase_r <= en ? phase_r + phaseIncr : 12'h000;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      iData <= '0;
      qData <= '0;
    end else if (ce) begin
      iData <= (en && gate) ? OUT_W'(cosV) : '0;
      qData <= (en && gate) ? OUT_W'(polarity ? -sinV : sinV) : '0;
    end
  end

  phaseStep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ce && en |=> phase_r == 12'($past(phase_r) + $past(phaseIncr)))
    else $error("phase did not advance by the increment");

  polarity_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ce && en && gate && polarity |=> qData == OUT_W'(-$past(sinV)))
    else $error("lower sideband Q not negated");

endmodule

// File: sim/iq_dac_model.sv
`timescale 1ns/1ps
module iq_dac_model #(
  parameter int SAMPLE_W = 9
) (
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  input  wire logic [SAMPLE_W-1:0] iData,
  input  wire logic [SAMPLE_W-1:0] qData,
  output int                       lastPeriod,
  output logic                     qSignAtCross,
  output int                       quietCycles
);
  // ******************************
  // converter side frequency meter
  // ******************************
  int   sinceCross;
  logic iSignPrev;

  // a rising cos crossing marks a whole period, so the meter needs no sample table
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastPeriod   <= 0;
      sinceCross   <= 0;
      qSignAtCross <= 1'b0;
      quietCycles  <= 0;
      iSignPrev    <= 1'b0;
    end else begin
      iSignPrev   <= iData[SAMPLE_W-1];
      quietCycles <= (iData == '0 && qData == '0) ? quietCycles + 1 : 0;
      if (iSignPrev && !iData[SAMPLE_W-1]) begin
        lastPeriod   <= sinceCross + 1;
        sinceCross   <= 0;
        qSignAtCross <= qData[SAMPLE_W-1];
      end else begin
        sinceCross <= sinceCross + 1;
      end
    end
  end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ******************************
  // signals and instances
  // ******************************
  localparam int LIMIT = 20000;
  logic        sys_clk;
  logic        arst_n;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [8:0]  iData;
  logic [8:0]  qData;
  logic [4:0]  pllDivide;
  logic        bandSel;
  logic        txBit;
  logic        irq;
  logic [31:0] rdata;
  logic        qSignAtCross;
  int          lastPeriod;
  int          quietCycles;
  int          numErrors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  iq_baseband_modulator dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .iData(iData), .qData(qData), .pllDivide(pllDivide), .bandSel(bandSel),
    .txBit(txBit), .irq(irq));
  iq_dac_model dac_u (.sys_clk(sys_clk), .arst_n(arst_n), .iData(iData), .qData(qData),
    .lastPeriod(lastPeriod), .qSignAtCross(qSignAtCross), .quietCycles(quietCycles));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      numErrors++;
      summarize();
    end
  end

  // ******************************
  // shared tasks
  // ******************************
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // hready is read right after the edge, so it is the value the slave drove into that edge
  task automatic bus(input logic isWrite, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= isWrite;
    hsize  <= iq_mod_pkg::HSIZE_WORD;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    rdata = hrdata;
  endtask

  task automatic regWrite(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {24'h0, d});
  endtask

  task automatic regCheck(input string what, input logic [7:0] idx, input logic [7:0] want);
    bus(1'b0, idx, 32'h0);
    check(what, rdata, {24'h0, want});
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // mid-bit sampling leaves half a bit of slack for load latency
  task automatic checkBits(input logic [15:0] bits, input int nb, input int per,
                           input logic ask, input int expPeriod);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (txBit !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    tick(per / 2 - 1);
    for (int i = 0; i < nb; i++) begin
      check("txBit", {31'h0, txBit}, {31'h0, bits[nb-1-i]});
      if (ask) begin
        check("ask gate", {31'h0, quietCycles > 3}, {31'h0, !bits[nb-1-i]});
      end
      if (!ask && i == nb - 1) begin
        check("fsk period", lastPeriod, expPeriod);
      end
      tick(per);
    end
  endtask

  // ******************************
  // scenarios
  // ******************************
  task automatic testReset;
    @(posedge sys_clk);
    check("bandSel", {31'h0, bandSel}, 32'h1);
    check("pllDivide", {27'h0, pllDivide}, {27'h0, iq_mod_pkg::DIV_315});
    check("iData off", {23'h0, iData}, 32'h0);
    check("txBit idle", {31'h0, txBit}, 32'h0);
    regCheck("state", iq_mod_pkg::STATE_IDX, 8'h40);
    regCheck("unmapped", 8'h00, 8'h00);
    regCheck("control", iq_mod_pkg::CTRL_IDX, 8'h00);
    $display("test reset done");
  endtask

  task automatic testBand;
    regWrite(iq_mod_pkg::BAND_IDX, 8'h00);
    tick(3);
    check("bandSel", {31'h0, bandSel}, 32'h0);
    check("pllDivide", {27'h0, pllDivide}, {27'h0, iq_mod_pkg::DIV_434});
    regWrite(iq_mod_pkg::BAND_IDX, 8'h80);
    tick(3);
    check("pllDivide", {27'h0, pllDivide}, {27'h0, iq_mod_pkg::DIV_315});
    $display("test band done");
  endtask

  task automatic testFreq;
    int offs[2] = '{64, 32};
    logic [8:0] frozen;
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h10);
    for (int k = 0; k < 2; k++) begin
      regWrite(iq_mod_pkg::OFFSET_IDX, 8'(offs[k]));
      tick(100);
      check("period", lastPeriod, 4096 / (4 * offs[k]));
    end
    check("q sign upper", {31'h0, qSignAtCross}, 32'h1);
    ce <= 1'b0;
    tick(1);
    frozen = iData;
    tick(5);
    check("ce freeze", {23'h0, iData}, {23'h0, frozen});
    ce <= 1'b1;
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h30);
    tick(100);
    check("q sign lower", {31'h0, qSignAtCross}, 32'h0);
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h34);
    tick(6);
    check("ram access quiet", {31'h0, quietCycles > 2}, 32'h1);
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h00);
    tick(6);
    check("disabled quiet", {31'h0, quietCycles > 2}, 32'h1);
    $display("test frequency done");
  endtask

  task automatic testTx;
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h04);
    for (int a = 0; a < 3; a++) begin
      regWrite(iq_mod_pkg::RAMADDR_IDX, 8'(a));
      regWrite(iq_mod_pkg::RAMDATA_IDX, 8'h10);
    end
    regWrite(iq_mod_pkg::RAMADDR_IDX, 8'h03);
    regWrite(iq_mod_pkg::SCALE_IDX, 8'h02);
    regWrite(iq_mod_pkg::OFFSET_IDX, 8'h3c);
    regWrite(iq_mod_pkg::IRQ_MASK_IDX, 8'h00);
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h10);
    regWrite(iq_mod_pkg::TXBUF_IDX, 8'ha5);
    regCheck("busy held", iq_mod_pkg::STATE_IDX, 8'hc0);
    tick(30);
    check("txBit held", {31'h0, txBit}, 32'h0);
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h12);
    fork
      checkBits(16'ha53c, 16, 2 * 2 * 3, 1'b0, 4096 / (4 * 60 + 16));
      begin
        regCheck("busy clear", iq_mod_pkg::STATE_IDX, 8'h40);
        regWrite(iq_mod_pkg::TXBUF_IDX, 8'h3c);
        regCheck("busy again", iq_mod_pkg::STATE_IDX, 8'hc0);
        regCheck("taken flag", iq_mod_pkg::IRQ_STS_IDX, 8'h01);
        check("irq masked", {31'h0, irq}, 32'h0);
      end
    join
    tick(24);
    check("txBit after", {31'h0, txBit}, 32'h0);
    regCheck("done flag", iq_mod_pkg::IRQ_STS_IDX, 8'h03);
    regWrite(iq_mod_pkg::IRQ_MASK_IDX, 8'h02);
    tick(3);
    check("irq raised", {31'h0, irq}, 32'h1);
    regWrite(iq_mod_pkg::IRQ_STS_IDX, 8'h03);
    tick(3);
    check("irq cleared", {31'h0, irq}, 32'h0);
    regCheck("status clear", iq_mod_pkg::IRQ_STS_IDX, 8'h00);
    $display("test transmit done");
  endtask

  task automatic testAsk;
    regWrite(iq_mod_pkg::CTRL_IDX, 8'h1a);
    regCheck("ready", iq_mod_pkg::STATE_IDX, 8'h40);
    regWrite(iq_mod_pkg::TXBUF_IDX, 8'hc3);
    checkBits(16'h00c3, 8, 2 * 2 * 3, 1'b1, 0);
    $display("test ask done");
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n  = 1'b0;
    ce      = 1'b1;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = iq_mod_pkg::HSIZE_WORD;
    hwdata  = 32'h0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    testReset();
    testBand();
    testFreq();
    testTx();
    testAsk();
    summarize();
  end
endmodule
